//--- icr_cfg_regs.sv
// Summary of operation
// RULE1 - lower register bits 7..3 pick level (1) or edge (0) for irq7..3
// RULE2 - upper bits 7,6 and 4..1 pick sensing for irq15,14,12..9
// RULE3 - upper bit 0 enables isa refresh and the port b refresh toggle
// RULE4 - reserved bits ignore writes; they read back as zero here
// RULE5 - host writes index 01 to port 22h, then uses data port 23h
// RULE6 - timing bits 7..6 give 1..4 register access wait states
// RULE7 - timing bits 5..4 give 1..4 wait states for 16-bit dma
// RULE8 - timing bits 3..2 give 1..4 wait states for 8-bit dma
// RULE9 - timing bit 1 set: memory read strobe with io write, else later
// RULE10 - timing bit 0 clear halves the dma clock, set runs it full
// RULE11 - timing register resets to c0h
// RULE12 - video routing bit 7 connects the video interrupt, else none
// RULE13 - codes 3..7 and 9..12 route to that irq; reserved codes nowhere
// RULE14 - codes 14 and 15 route to irq14 and irq15
// RULE15 - sync bypass bit 0 set removes the pci/isa synchronizers; here it only drives sync_bypass_o, the isa clock flops stay in use
// RULE16 - software should bypass only when isa clock comes from pci clock
`include "icr_params.svh"
`default_nettype none
module icr_cfg_regs (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire icr_pkg::icr_byte_t io_wdata_i,
  output icr_pkg::icr_byte_t io_rdata_o,
  output logic io_ack_o,
  input wire logic isa_bus_clock_i,
  input wire logic refresh_req_i,
  input wire logic video_module_interrupt_i,
  output logic [15:0] irq_level_sense_o,
  output logic refresh_enable_o,
  output logic portb_refresh_o,
  output logic [1:0] ipc_ws_code_o,
  output logic [1:0] dma16_ws_code_o,
  output logic [1:0] dma8_ws_code_o,
  output logic memr_with_iow_o,
  output logic dma_clk_full_o,
  output logic dma_clk_tick_o,
  output logic sync_bypass_o,
  output logic [15:0] video_irq_o
);
  import icr_pkg::*;
  icr_state_t q;
  icr_state_t next_q;
  logic isa_rise;
  logic hit_idx;
  logic hit_data;
  // ==========================================================================
  // register read mux; reserved positions read as zero
  function automatic icr_byte_t read_reg(input icr_byte_t idx,
                                         input icr_state_t s);
    icr_byte_t r;
    r = `ICR_UNMAPPED_READ;
    unique case (idx)
      `ICR_IDX_TIMING: r = s.timing;
      `ICR_IDX_LOWER: r = s.lower & `ICR_MASK_LOWER; // RULE4
      `ICR_IDX_UPPER: r = s.upper & `ICR_MASK_UPPER; // RULE4
      `ICR_IDX_VIDEO: r = s.video & `ICR_MASK_VIDEO; // RULE4
      `ICR_IDX_SYNC: r = s.sync & `ICR_MASK_SYNC; // RULE4
      default: r = `ICR_UNMAPPED_READ;
    endcase
    return r;
  endfunction
  // ==========================================================================
  // masked merge keeps reserved bits untouched by writes
  function automatic icr_byte_t merge(input icr_byte_t old_v,
                                      input icr_byte_t new_v,
                                      input icr_byte_t mask);
    return (new_v & mask) | (old_v & ~mask); // RULE4
  endfunction
  // ==========================================================================
  // io decode
  assign hit_idx = (io_addr_i == `ICR_IDX_PORT);
  assign hit_data = (io_addr_i == `ICR_DATA_PORT);
  // ==========================================================================
  // isa clock edge: second and third flops must agree before it counts,
  // the first flop only feeds the second
  assign isa_rise = (q.sync_bypass_control[1] == q.sync_bypass_control[2]) &&
                    (q.sync_bypass_control[1] != q.isa_filt) && q.sync_bypass_control[1];
  // ==========================================================================
  // next state
  always_comb begin
    next_q = q;
    next_q.ack = 1'b0;
    next_q.dma_tick = 1'b0;
    next_q.sync_bypass_control = {q.sync_bypass_control[1:0], isa_bus_clock_i};
    if (q.sync_bypass_control[1] == q.sync_bypass_control[2]) begin
      next_q.isa_filt = q.sync_bypass_control[1];
    end
    // dma clock: every isa edge, or every other one when halved
    if (isa_rise) begin
      if (q.timing[`ICR_TIM_DCLK]) begin
        next_q.dma_tick = 1'b1; // RULE10
      end else begin
        next_q.dma_div = ~q.dma_div; // RULE10
        next_q.dma_tick = q.dma_div; // RULE10
      end
    end
    // refresh indicator only moves while refresh is on
    if (q.upper[`ICR_UP_REFRESH] && refresh_req_i) begin
      next_q.portb_refresh = ~q.portb_refresh; // RULE3
    end
    unique case (q.phase)
      ICR_IDLE: begin
        if ((io_wr_i || io_rd_i) && hit_idx) begin
          if (io_wr_i) begin
            next_q.idx = io_wdata_i; // RULE5
          end
          if (io_rd_i) begin
            next_q.rdata = q.idx;
          end
          next_q.ack = 1'b1;
        end else if ((io_wr_i || io_rd_i) && hit_data) begin
          if (io_rd_i) begin
            next_q.rdata = read_reg(q.idx, q);
          end
          if (io_wr_i) begin
            unique case (q.idx)
              `ICR_IDX_TIMING: begin
                next_q.timing = merge(q.timing, io_wdata_i,
                                      `ICR_MASK_TIMING); // RULE5
              end
              `ICR_IDX_LOWER: begin
                next_q.lower = merge(q.lower, io_wdata_i,
                                     `ICR_MASK_LOWER); // RULE1
              end
              `ICR_IDX_UPPER: begin
                next_q.upper = merge(q.upper, io_wdata_i,
                                     `ICR_MASK_UPPER); // RULE2
              end
              `ICR_IDX_VIDEO: begin
                next_q.video = merge(q.video, io_wdata_i,
                                     `ICR_MASK_VIDEO); // RULE12
              end
              `ICR_IDX_SYNC: begin
                next_q.sync = merge(q.sync, io_wdata_i,
                                    `ICR_MASK_SYNC); // RULE15
              end
              default: begin
                next_q.sync = q.sync;
              end
            endcase
          end
          // wait states use the setting in force before this access
          next_q.ws_left = {1'b0, q.timing[`ICR_TIM_IPC_WS]} +
                           `ICR_WS_ONE; // RULE6
          next_q.phase = ICR_WAIT;
        end
      end
      ICR_WAIT: begin
        // accesses arriving while busy are dropped, not queued
        if (isa_rise) begin
          if (q.ws_left == `ICR_WS_ONE) begin
            next_q.ack = 1'b1; // RULE6
            next_q.ws_left = `ICR_WS_ZERO;
            next_q.phase = ICR_IDLE;
          end else begin
            next_q.ws_left = q.ws_left - `ICR_WS_ONE; // RULE6
          end
        end
      end
    endcase
    if (srst_i) begin
      next_q.phase = ICR_IDLE;
      next_q.idx = `ICR_RST_BYTE;
      next_q.timing = `ICR_RST_TIMING; // RULE11
      next_q.lower = `ICR_RST_LOWER;
      next_q.upper = `ICR_RST_UPPER;
      next_q.video = `ICR_RST_VIDEO;
      next_q.sync = `ICR_RST_SYNC; // RULE15
      next_q.rdata = `ICR_RST_BYTE;
      next_q.ack = 1'b0;
      next_q.ws_left = `ICR_WS_ZERO;
      next_q.sync_bypass_control = 3'h0;
      next_q.isa_filt = 1'b0;
      next_q.dma_div = 1'b0;
      next_q.dma_tick = 1'b0;
      next_q.portb_refresh = 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    q <= next_q;
  end
  // ==========================================================================
  // outputs
  assign io_rdata_o = q.rdata;
  assign io_ack_o = q.ack;
  always_comb begin
    irq_level_sense_o = 16'h0000;
    irq_level_sense_o[`ICR_IRQ_LOW] = q.lower[`ICR_LOW_SENSE]; // RULE1
    irq_level_sense_o[`ICR_IRQ_HI] = q.upper[`ICR_UP_SENSE_HI]; // RULE2
    irq_level_sense_o[`ICR_IRQ_MID] = q.upper[`ICR_UP_SENSE_MID]; // RULE2
  end
  assign refresh_enable_o = q.upper[`ICR_UP_REFRESH]; // RULE3
  assign portb_refresh_o = q.portb_refresh;
  assign ipc_ws_code_o = q.timing[`ICR_TIM_IPC_WS]; // RULE6
  assign dma16_ws_code_o = q.timing[`ICR_TIM_DMA16_WS]; // RULE7
  assign dma8_ws_code_o = q.timing[`ICR_TIM_DMA8_WS]; // RULE8
  assign memr_with_iow_o = q.timing[`ICR_TIM_MEMR]; // RULE9
  assign dma_clk_full_o = q.timing[`ICR_TIM_DCLK]; // RULE10
  assign dma_clk_tick_o = q.dma_tick;
  // software is expected to set this only with a pci-derived isa clock
  assign sync_bypass_o = q.sync[`ICR_SYNC_BYP]; // RULE15 RULE16
  // ==========================================================================
  // video interrupt routing
  icr_vmi_router u_router (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .video_module_interrupt_i(video_module_interrupt_i),
    .enable_i(q.video[`ICR_VID_EN]),
    .select_i(q.video[`ICR_VID_SEL]),
    .irq_o(video_irq_o)
  );
endmodule // icr_cfg_regs
`default_nettype wire

//--- icr_params.svh
`ifndef ICR_PARAMS_SVH
`define ICR_PARAMS_SVH
// ==========================================================================
// io ports of the index/data pair
`define ICR_IDX_PORT 8'h22
`define ICR_DATA_PORT 8'h23
// ==========================================================================
// register indices
`define ICR_IDX_TIMING 8'h01
`define ICR_IDX_LOWER 8'h56
`define ICR_IDX_UPPER 8'h57
`define ICR_IDX_VIDEO 8'h58
`define ICR_IDX_SYNC 8'h59
// ==========================================================================
// reset values
`define ICR_RST_TIMING 8'hc0
`define ICR_RST_LOWER 8'h00
`define ICR_RST_UPPER 8'h00
`define ICR_RST_VIDEO 8'h00
`define ICR_RST_SYNC 8'h00
`define ICR_RST_BYTE 8'h00
`define ICR_UNMAPPED_READ 8'h00
// ==========================================================================
// implemented bits; the rest are reserved
`define ICR_MASK_TIMING 8'hff
`define ICR_MASK_LOWER 8'hf8
`define ICR_MASK_UPPER 8'hdf
`define ICR_MASK_VIDEO 8'h8f
`define ICR_MASK_SYNC 8'h01
// ==========================================================================
// field positions
`define ICR_TIM_IPC_WS 7:6
`define ICR_TIM_DMA16_WS 5:4
`define ICR_TIM_DMA8_WS 3:2
`define ICR_TIM_MEMR 1
`define ICR_TIM_DCLK 0
`define ICR_LOW_SENSE 7:3
`define ICR_UP_SENSE_HI 7:6
`define ICR_UP_SENSE_MID 4:1
`define ICR_UP_REFRESH 0
`define ICR_VID_EN 7
`define ICR_VID_SEL 3:0
`define ICR_SYNC_BYP 0
// ==========================================================================
// irq line positions and routing codes
`define ICR_IRQ_LOW 7:3
`define ICR_IRQ_HI 15:14
`define ICR_IRQ_MID 12:9
`define ICR_VID_MIN 4'h3
`define ICR_VID_RSV_A 4'h8
`define ICR_VID_RSV_B 4'hd
// ==========================================================================
// wait state counting: count is code plus one
`define ICR_WS_ONE 3'h1
`define ICR_WS_ZERO 3'h0
`endif

//--- icr_pkg.sv
`default_nettype none
package icr_pkg;
  typedef logic [7:0] icr_byte_t;
  typedef enum logic [0:0] {
    ICR_IDLE = 1'b0,
    ICR_WAIT = 1'b1
  } icr_phase_t;
  typedef struct packed {
    icr_phase_t phase;
    icr_byte_t idx;
    icr_byte_t timing;
    icr_byte_t lower;
    icr_byte_t upper;
    icr_byte_t video;
    icr_byte_t sync;
    icr_byte_t rdata;
    logic ack;
    logic [2:0] ws_left;
    logic [2:0] sync_bypass_control;
    logic isa_filt;
    logic dma_div;
    logic dma_tick;
    logic portb_refresh;
  } icr_state_t;
  typedef struct packed {
    logic [15:0] irq;
  } icr_route_state_t;
endpackage : icr_pkg
`default_nettype wire

//--- icr_vmi_router.sv
`include "icr_params.svh"
`default_nettype none
module icr_vmi_router (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic video_module_interrupt_i,
  input wire logic enable_i,
  input wire logic [3:0] select_i,
  output logic [15:0] irq_o
);
  import icr_pkg::*;
  icr_route_state_t q;
  icr_route_state_t next_q;
  logic valid;
  logic [15:0] hit;
  // ========================================================================
  // code decode
  // reserved codes must never drive a line
  assign valid = (select_i >= `ICR_VID_MIN) &&
                 (select_i != `ICR_VID_RSV_A) &&
                 (select_i != `ICR_VID_RSV_B); // RULE13 RULE14
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_line
      assign hit[i] = valid && (select_i == 4'(i)); // RULE13 RULE14
    end
  endgenerate
  // ========================================================================
  // state
  always_comb begin
    next_q = q;
    if (enable_i && video_module_interrupt_i) begin
      next_q.irq = hit; // RULE12
    end else begin
      next_q.irq = 16'h0000; // RULE12
    end
    if (srst_i) begin
      next_q.irq = 16'h0000;
    end
  end
  always_ff @(posedge clk_i) begin
    q <= next_q;
  end
  assign irq_o = q.irq;
endmodule // icr_vmi_router
`default_nettype wire

//--- icr_cfg_regs_properties.sv
`include "icr_params.svh"
`default_nettype none
// ==========================================================================
// port checks for the configuration bank
module icr_cfg_regs_properties (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic io_ack_o,
  input wire logic refresh_req_i,
  input wire logic video_module_interrupt_i,
  input wire logic [15:0] irq_level_sense_o,
  input wire logic refresh_enable_o,
  input wire logic portb_refresh_o,
  input wire logic [1:0] ipc_ws_code_o,
  input wire logic [1:0] dma16_ws_code_o,
  input wire logic [1:0] dma8_ws_code_o,
  input wire logic memr_with_iow_o,
  input wire logic dma_clk_full_o,
  input wire logic dma_clk_tick_o,
  input wire logic sync_bypass_o,
  input wire logic [15:0] video_irq_o
);
  // pend tracks a data port access still waiting for its ack
  logic pend;
  wire logic req = io_wr_i | io_rd_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  always_ff @(posedge clk_i) begin
    if (srst_i) pend <= 1'b0;
    else if (req && io_addr_i == `ICR_DATA_PORT && !pend) pend <= 1'b1;
    else if (io_ack_o) pend <= 1'b0;
  end
  a_sense_rsv: assert property (irq_level_sense_o[2:0] == 3'h0 &&
    !irq_level_sense_o[8] && !irq_level_sense_o[13]) else $error("sense");
  a_video_route: assert property ($onehot0(video_irq_o) &&
    video_irq_o[2:0] == 3'h0 && !video_irq_o[8] && !video_irq_o[13])
    else $error("video route");
  a_video_cause: assert property (video_irq_o != 16'h0 |->
    $past(video_module_interrupt_i)) else $error("video cause");
  a_refresh_tgl: assert property (refresh_req_i && refresh_enable_o |=>
    portb_refresh_o != $past(portb_refresh_o)) else $error("toggle");
  a_refresh_hold: assert property (!(refresh_req_i && refresh_enable_o)
    |=> $stable(portb_refresh_o)) else $error("hold");
  a_tick_half: assert property (dma_clk_tick_o && !dma_clk_full_o
    |=> !dma_clk_tick_o [*3]) else $error("tick");
  a_reset_vals: assert property ($fell(srst_i) |->
    {ipc_ws_code_o, dma16_ws_code_o, dma8_ws_code_o, memr_with_iow_o,
    dma_clk_full_o} == `ICR_RST_TIMING && !sync_bypass_o) else $error("rst");
  a_index_ack: assert property (req && io_addr_i == `ICR_IDX_PORT &&
    !pend |=> io_ack_o) else $error("index ack");
  a_data_ack: assert property (req && io_addr_i == `ICR_DATA_PORT &&
    !pend |=> !io_ack_o ##[1:60] io_ack_o) else $error("data ack");
  a_other_quiet: assert property (req && !pend &&
    io_addr_i != `ICR_IDX_PORT && io_addr_i != `ICR_DATA_PORT |=> !io_ack_o)
    else $error("stray ack");
  c_data_read: cover property (req && io_rd_i && io_addr_i == `ICR_DATA_PORT);
  c_half_tick: cover property (dma_clk_tick_o && !dma_clk_full_o);
  c_video_top: cover property (video_irq_o[15]);
endmodule // icr_cfg_regs_properties
bind icr_cfg_regs icr_cfg_regs_properties i_icr_cfg_regs_properties (.clk_i,
  .srst_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_ack_o, .refresh_req_i,
  .video_module_interrupt_i, .irq_level_sense_o, .refresh_enable_o,
  .portb_refresh_o, .ipc_ws_code_o, .dma16_ws_code_o, .dma8_ws_code_o,
  .memr_with_iow_o, .dma_clk_full_o, .dma_clk_tick_o, .sync_bypass_o,
  .video_irq_o);
`default_nettype wire

//--- tb.sv
`include "icr_params.svh"
`default_nettype none
// ==========================================================================
// bench
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import icr_pkg::*;
  logic clk_i, srst_i, io_wr_i, io_rd_i, isa_bus_clock_i, refresh_req_i;
  logic video_module_interrupt_i, io_ack_o, refresh_enable_o, pb;
  logic portb_refresh_o, memr_with_iow_o, dma_clk_full_o, dma_clk_tick_o;
  logic sync_bypass_o;
  logic [7:0] io_addr_i, v;
  icr_byte_t io_wdata_i, io_rdata_o, q;
  logic [15:0] irq_level_sense_o, video_irq_o;
  logic [1:0] ipc_ws_code_o, dma16_ws_code_o, dma8_ws_code_o;
  logic [7:0] m [5];
  int errors, num_checks, cyc, i, k, cnt, c0;
  int unsigned seed = 18;
  localparam logic [7:0] IX [5] = '{`ICR_IDX_TIMING, `ICR_IDX_LOWER,
    `ICR_IDX_UPPER, `ICR_IDX_VIDEO, `ICR_IDX_SYNC};
  localparam logic [7:0] MK [5] = '{`ICR_MASK_TIMING, `ICR_MASK_LOWER,
    `ICR_MASK_UPPER, `ICR_MASK_VIDEO, `ICR_MASK_SYNC};
  localparam logic [7:0] RV [5] = '{`ICR_RST_TIMING, `ICR_RST_LOWER,
    `ICR_RST_UPPER, `ICR_RST_VIDEO, `ICR_RST_SYNC};
  icr_cfg_regs i_icr_cfg_regs (.clk_i, .srst_i, .io_addr_i, .io_wr_i,
    .io_rd_i, .io_wdata_i, .io_rdata_o, .io_ack_o, .isa_bus_clock_i,
    .refresh_req_i, .video_module_interrupt_i, .irq_level_sense_o,
    .refresh_enable_o, .portb_refresh_o, .ipc_ws_code_o, .dma16_ws_code_o,
    .dma8_ws_code_o, .memr_with_iow_o, .dma_clk_full_o, .dma_clk_tick_o,
    .sync_bypass_o, .video_irq_o);
  task automatic end_of_test();
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // one strobe pulse, then a bounded wait for the ack
  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk_i) #1;
    io_addr_i = a;
    io_wr_i = w;
    io_rd_i = !w;
    io_wdata_i = d;
    @(posedge clk_i) #1;
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
    for (n = 0; n < 100 && io_ack_o !== 1'b1; n++) @(posedge clk_i) #1;
    if (n == 100) begin
      errors++;
      end_of_test();
    end
    q = io_rdata_o;
  endtask
  task automatic wr(input logic [7:0] x, input logic [7:0] d);
    acc(`ICR_IDX_PORT, 1'b1, x);
    acc(`ICR_DATA_PORT, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] x);
    acc(`ICR_IDX_PORT, 1'b1, x);
    acc(`ICR_DATA_PORT, 1'b0, 8'h00);
  endtask
  task automatic cmp();
    logic [3:0] c;
    logic [15:0] ev;
    c = m[3][3:0];
    ev = (m[3][7] && video_module_interrupt_i && c >= 4'h3 && c != 4'h8 &&
      c != 4'hd) ? 16'h1 << c : 16'h0;
    chk(irq_level_sense_o, {m[2][7:6], 1'b0, m[2][4:1], 1'b0, m[1][7:3],
      3'h0});
    chk(refresh_enable_o, m[2][0]);
    chk({ipc_ws_code_o, dma16_ws_code_o, dma8_ws_code_o, memr_with_iow_o,
      dma_clk_full_o}, m[0]);
    chk(sync_bypass_o, m[4][0]);
    chk(video_irq_o, ev);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // isa clock derived from the bus clock at an eighth of its rate,
  // which is what makes random sync bypass settings legal here
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    isa_bus_clock_i <= #1 cyc[2];
  end
  // ticks are counted on the falling edge, where the output has settled
  always @(negedge clk_i) begin
    if (dma_clk_tick_o === 1'b1) cnt <= cnt + 1;
  end
  initial begin
    srst_i = 1'b1;
    {io_addr_i, io_wr_i, io_rd_i, io_wdata_i, refresh_req_i} = '0;
    {video_module_interrupt_i, pb} = '0;
    m = RV;
    repeat (10) @(posedge clk_i);
    #1 srst_i = 1'b0;
    cmp();
    for (k = 0; k < 5; k++) begin
      rd(IX[k]);
      chk(q, RV[k]);
    end
    for (i = 0; i < 12; i++) begin
      v = xs();
      video_module_interrupt_i = v[0];
      for (k = 0; k < 5; k++) begin
        v = xs();
        m[k] = v & MK[k];
        wr(IX[k], v);
        rd(IX[k]);
        chk(q, m[k]);
      end
      cmp();
      @(posedge clk_i) #1 refresh_req_i = 1'b1;
      @(posedge clk_i) #1 refresh_req_i = 1'b0;
      pb ^= m[2][0];
      chk(portb_refresh_o, pb);
    end
    video_module_interrupt_i = 1'b1;
    for (k = 0; k < 17; k++) begin
      v = (k == 16) ? 8'h05 : {4'h8, k[3:0]};
      m[3] = v;
      wr(`ICR_IDX_VIDEO, v);
      cmp();
    end
    for (k = 0; k < 2; k++) begin
      m[0] = {7'h00, k[0]};
      wr(`ICR_IDX_TIMING, m[0]);
      c0 = cnt;
      repeat (400) @(posedge clk_i);
      chk(cnt - c0 >= 24 + 25 * k &&
        cnt - c0 <= 26 + 25 * k, 16'h1);
    end
    wr(8'h10, 8'haa);
    rd(8'h10);
    chk(q, `ICR_UNMAPPED_READ);
    acc(`ICR_IDX_PORT, 1'b0, 8'h00);
    chk(q, 8'h10);
    @(posedge clk_i) #1;
    io_addr_i = 8'h30;
    io_wr_i = 1'b1;
    @(posedge clk_i) #1 io_wr_i = 1'b0;
    repeat (8) @(posedge clk_i) #1 chk(io_ack_o, 16'h0);
    srst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 srst_i = 1'b0;
    m = RV;
    cmp();
    chk(portb_refresh_o, 16'h0);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
